/* common/sitp_pkg.sv */
package sitp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus addresses selected by the address_select_strap pin
  localparam logic [6:0] ADDR_STRAP_HI = 7'h1d;
  localparam logic [6:0] ADDR_STRAP_LO = 7'h53;

  ////////////////////////////////////////////////////////////////////////////
  // Byte framing
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [7:0] PTR_STEP = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, link clock period as used by the oversampling logic
  localparam int LINK_CLK_PERIOD_NS = 125;
  localparam int SCL_FAST_KHZ = 400;
  localparam int SCL_STD_KHZ = 100;
  localparam int SCL_MIN_PERIOD_NS = 1000000 / SCL_FAST_KHZ;
  localparam int SCL_LOW_MIN_NS = 1300;
  // Longest time rounds down: the access handshake must fit in one SCL low phase
  localparam int SCL_LOW_CYC = SCL_LOW_MIN_NS / LINK_CLK_PERIOD_NS;
  // Link samples taken per SCL period at the fast grade
  localparam int SAMPLES_PER_SCL = SCL_MIN_PERIOD_NS / LINK_CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } sitp_link_st_t;

endpackage

/* hw/sitp_sync.sv */
`timescale 1ns/100ps
module sitp_sync import sitp_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rst,
  // Levels from another domain
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

/* hw/sitp_sys_access.sv */
`timescale 1ns/100ps
module sitp_sys_access import sitp_pkg::*; (
  // System clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Request from the link domain, fields held stable while the toggle is pending
  input wire logic i_req_tgl,
  input wire logic i_req_wr,
  input wire logic [7:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  output logic o_ack_tgl,
  output logic [7:0] o_rdata,
  // Register space
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);

  logic req_s;
  logic seen_q, seen_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic cap_q, cap_d;
  logic ack_q, ack_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic req_new;

  sitp_sync #(.W(1)) u_req_sync (
    .i_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_req_tgl),
    .o_sync(req_s)
  );

  assign req_new = req_s ^ seen_q;

  always_comb begin
    seen_d = req_s;
    wr_d = req_new & i_req_wr;
    rd_d = req_new & ~i_req_wr;
    addr_d = req_new ? i_req_addr : addr_q;
    wdata_d = req_new ? i_req_wdata : wdata_q;
    // Read data is valid the cycle after the strobe
    cap_d = rd_q;
    rdata_d = cap_q ? i_reg_rdata : rdata_q;
    ack_d = ack_q ^ (wr_q | cap_q);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cap_q <= 1'b0;
      ack_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      seen_q <= seen_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cap_q <= cap_d;
      ack_q <= ack_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_wr = wr_q;
  assign o_reg_rd = rd_q;
  assign o_reg_addr = addr_q;
  assign o_reg_wdata = wdata_q;
  assign o_rdata = rdata_q;
  assign o_ack_tgl = ack_q;

  chk_rd_answer: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    rd_q |=> ##1 (ack_q != $past(ack_q, 2) && rdata_q == $past(i_reg_rdata)))
    else $error("read answer not returned two cycles after the strobe");

  chk_wr_answer: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_q |=> (!wr_q && ack_q != $past(ack_q)))
    else $error("write strobe not single or not answered");

endmodule

/* hw/sitp_target.sv */
`timescale 1ns/100ps
// Operation
// - The port acts as a two-wire target only while the port select input is held high.
// - Bus clock rates up to 400 kHz and the 100 kHz grade are handled, never faster.
// - Single and multi-byte register reads and writes started by the controller are served.
// - With the strap high the target answers to 7-bit address 0x1d plus direction bit.
// - With the strap low the target answers to 7-bit address 0x53 plus direction bit.
module sitp_target import sitp_pkg::*; (
  // Clocks and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  // Board straps
  input wire logic i_port_sel,
  input wire logic i_addr_sel_strap,
  // Bus clock pin, open drain
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  // Bus data pin, open drain
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // Register space, system clock domain
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);

  localparam int HS_BOUND = SCL_LOW_CYC;
  ////////////////////////////////////////////////////////////////////////////
  // Link domain reset: asserted at once, released on the link clock
  logic [1:0] rst_link_q;
  logic lrst;
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_link_q <= 2'h3;
    end else begin
      rst_link_q <= {rst_link_q[0], 1'b0};
    end
  end

  assign lrst = rst_link_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and crossing back from the register side
  logic scl_s, sda_s, port_s, strap_s;
  logic ack_s, ack_tgl;
  logic [7:0] rdata;
  sitp_sync #(.W(4)) u_pin_sync (
    .i_clk(i_link_clk),
    .i_rst(lrst),
    .i_async({i_scl, i_sda, i_port_sel, i_addr_sel_strap}),
    .o_sync({scl_s, sda_s, port_s, strap_s})
  );

  sitp_link_st_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic first_q, first_d;
  logic ack_on_q, ack_on_d;
  logic tx_pend_q, tx_pend_d;
  logic req_tgl_q, req_tgl_d;
  logic req_wr_q, req_wr_d;
  logic [7:0] req_addr_q, req_addr_d;
  logic [7:0] req_wdata_q, req_wdata_d;
  logic sda_oe_n_q, sda_oe_n_d;
  logic scl_oe_n_q, scl_oe_n_d;
  logic scl_prev_q, sda_prev_q;
  logic drive_lvl_q;

  sitp_sync #(.W(1)) u_ack_sync (
    .i_clk(i_link_clk),
    .i_rst(lrst),
    .i_async(ack_tgl),
    .o_sync(ack_s)
  );
  sitp_sys_access u_access (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_req_tgl(req_tgl_q),
    .i_req_wr(req_wr_q),
    .i_req_addr(req_addr_q),
    .i_req_wdata(req_wdata_q),
    .o_ack_tgl(ack_tgl),
    .o_rdata(rdata),
    .o_reg_wr(o_reg_wr),
    .o_reg_rd(o_reg_rd),
    .o_reg_addr(o_reg_addr),
    .o_reg_wdata(o_reg_wdata),
    .i_reg_rdata(i_reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus events, seen on synchronised pins only
  logic busy, scl_rise, scl_fall, start_ev, stop_ev;
  logic [6:0] dev_addr;
  // Handshake outstanding; its fields must not change meanwhile
  assign busy = req_tgl_q ^ ack_s;
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign dev_addr = strap_s ? ADDR_STRAP_HI : ADDR_STRAP_LO;

  ////////////////////////////////////////////////////////////////////////////
  // Target state machine
  always_comb begin
    logic issue_rd;
    issue_rd = 1'b0;
    st_d = st_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    first_d = first_q;
    ack_on_d = ack_on_q;
    tx_pend_d = tx_pend_q;
    req_tgl_d = req_tgl_q;
    req_wr_d = req_wr_q;
    req_addr_d = req_addr_q;
    req_wdata_d = req_wdata_q;
    sda_oe_n_d = sda_oe_n_q;
    if (!port_s) begin
      // Port select low: bus belongs to another interface, stay silent
      st_d = ST_IDLE;
      sda_oe_n_d = 1'b1;
      tx_pend_d = 1'b0;
    end else if (start_ev) begin
      // A repeated start is handled like a first start
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      sda_oe_n_d = 1'b1;
      tx_pend_d = 1'b0;
    end else if (stop_ev) begin
      st_d = ST_IDLE;
      sda_oe_n_d = 1'b1;
      tx_pend_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == BIT_LAST) begin
              if (shift_q[6:0] == dev_addr) begin
                st_d = ST_ADDR_ACK;
                rw_d = sda_s;
                ack_on_d = 1'b0;
              end else begin
                st_d = ST_IDLE;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (scl_fall) begin
            if (!ack_on_q) begin
              ack_on_d = 1'b1;
              sda_oe_n_d = 1'b0;
            end else begin
              ack_on_d = 1'b0;
              sda_oe_n_d = 1'b1;
              cnt_d = 4'h0;
              if (st_q == ST_ADDR_ACK && rw_q) begin
                st_d = ST_TX;
                issue_rd = 1'b1;
              end else begin
                st_d = ST_RX;
                first_d = (st_q == ST_ADDR_ACK);
              end
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == BIT_LAST) begin
              st_d = ST_RX_ACK;
              ack_on_d = 1'b0;
              if (first_q) begin
                // First byte after a write address is the register pointer
                ptr_d = {shift_q[6:0], sda_s};
              end else begin
                req_tgl_d = ~req_tgl_q;
                req_wr_d = 1'b1;
                req_addr_d = ptr_q;
                req_wdata_d = {shift_q[6:0], sda_s};
                ptr_d = ptr_q + PTR_STEP;
              end
            end
          end
        end
        ST_TX: begin
          if (tx_pend_q) begin
            if (!busy) begin
              tx_pend_d = 1'b0;
              sda_oe_n_d = rdata[7];
              shift_d = {rdata[6:0], 1'b0};
              ptr_d = ptr_q + PTR_STEP;
            end
          end else if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == BIT_DONE) begin
              st_d = ST_TX_ACK;
              sda_oe_n_d = 1'b1;
              ack_on_d = 1'b0;
            end else begin
              sda_oe_n_d = shift_q[7];
              shift_d = {shift_q[6:0], 1'b0};
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            // Controller not acknowledging ends the read burst
            if (sda_s) begin
              st_d = ST_IDLE;
            end else begin
              ack_on_d = 1'b1;
            end
          end else if (scl_fall && ack_on_q) begin
            ack_on_d = 1'b0;
            st_d = ST_TX;
            cnt_d = 4'h0;
            issue_rd = 1'b1;
          end
        end
      endcase
    end
    if (issue_rd) begin
      tx_pend_d = 1'b1;
      req_tgl_d = ~req_tgl_q;
      req_wr_d = 1'b0;
      req_addr_d = ptr_q;
    end
    // Stretch SCL low only once it is already low, so no false edge is made;
    // the handshake is short, so at 400 kHz the stretch stays brief
    scl_oe_n_d = ~((busy | tx_pend_q) & (~scl_s | ~scl_oe_n_q));
  end

  always_ff @(posedge i_link_clk or posedge lrst) begin
    if (lrst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ack_on_q <= 1'b0;
      tx_pend_q <= 1'b0;
      req_tgl_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_addr_q <= 8'h00;
      req_wdata_q <= 8'h00;
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      scl_prev_q <= 1'b0;
      sda_prev_q <= 1'b0;
      drive_lvl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      first_q <= first_d;
      ack_on_q <= ack_on_d;
      tx_pend_q <= tx_pend_d;
      req_tgl_q <= req_tgl_d;
      req_wr_q <= req_wr_d;
      req_addr_q <= req_addr_d;
      req_wdata_q <= req_wdata_d;
      sda_oe_n_q <= sda_oe_n_d;
      scl_oe_n_q <= scl_oe_n_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      drive_lvl_q <= 1'b0;
    end
  end

  // Open drain: the pins are only ever pulled low
  assign o_scl_out = drive_lvl_q;
  assign o_sda_out = drive_lvl_q;
  assign o_scl_oe_n = scl_oe_n_q;
  assign o_sda_oe_n = sda_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_link @(posedge i_link_clk);
  endclocking
  default disable iff (lrst);
  sequence seq_addr_done;
    port_s && st_q == ST_ADDR && scl_rise && cnt_q == BIT_LAST;
  endsequence
  sequence seq_ack_open;
    port_s && !start_ev && !stop_ev && st_q == ST_ADDR_ACK && scl_fall && !ack_on_q;
  endsequence
  chk_port_off: assert property (!port_s |=> (st_q == ST_IDLE && sda_oe_n_q))
    else $error("target active while port select is low");
  chk_addr_high: assert property (
    seq_addr_done ##0 (strap_s && shift_q[6:0] == ADDR_STRAP_HI) |=> st_q == ST_ADDR_ACK)
    else $error("high strap address not accepted");
  chk_addr_low: assert property (
    seq_addr_done ##0 (!strap_s && shift_q[6:0] == ADDR_STRAP_LO) |=> st_q == ST_ADDR_ACK)
    else $error("low strap address not accepted");
  chk_addr_miss: assert property (
    seq_addr_done ##0 (shift_q[6:0] != dev_addr) |=> st_q == ST_IDLE)
    else $error("foreign address accepted");
  chk_ack_drive: assert property (
    seq_ack_open |=> (!sda_oe_n_q && ack_on_q))
    else $error("address acknowledge not driven");
  chk_ptr_step: assert property (
    (port_s && st_q == ST_RX && scl_rise && cnt_q == BIT_LAST && !first_q)
    |=> ptr_q == $past(ptr_q) + PTR_STEP)
    else $error("pointer not advanced after write byte");
  chk_busy_bound: assert property (busy |-> ##[1:HS_BOUND] !busy)
    else $error("register handshake outlasts the bus clock low time");
  chk_tx_load: assert property (
    (port_s && !start_ev && !stop_ev && st_q == ST_TX && tx_pend_q && !busy)
    |=> (sda_oe_n_q == $past(rdata[7]) && !tx_pend_q))
    else $error("read byte not presented on the data pin");

endmodule

/* tb/sitp_ctl_model.sv */
`timescale 1ns/100ps
module sitp_ctl_model (
  // Wire levels seen on the bus
  input wire logic i_scl,
  input wire logic i_sda,
  // Open-drain pulls of the controller
  output logic o_scl_low,
  output logic o_sda_low
);
  // Fast grade: 2.5 us cycle, low above 1.3 us, high above 0.6 us
  localparam int T_LOW = 1400;
  localparam int T_HIGH = 1100;

  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The target may stretch the low phase, so wait on the wire, not on our pull
  task automatic scl_up();
    int n;
    n = 0;
    o_scl_low = 1'b0;
    while (i_scl !== 1'b1 && n < 800) begin
      #25;
      n++;
    end
  endtask

  task automatic clk_bit(input logic b, output logic s);
    #(T_LOW / 2);
    o_sda_low = !b;
    #(T_LOW / 2);
    scl_up();
    #(T_HIGH / 2);
    s = i_sda;
    #(T_HIGH / 2);
    o_scl_low = 1'b1;
  endtask

  // Serves both as first start and as repeated start
  task automatic start();
    #(T_LOW / 2);
    o_sda_low = 1'b0;
    #(T_LOW / 2);
    scl_up();
    #T_HIGH;
    o_sda_low = 1'b1;
    #T_HIGH;
    o_scl_low = 1'b1;
  endtask

  // Ends with a free bus for longer than the minimum gap before a start
  task automatic stop();
    #(T_LOW / 2);
    o_sda_low = 1'b1;
    #(T_LOW / 2);
    scl_up();
    #T_HIGH;
    o_sda_low = 1'b0;
    #T_LOW;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  // A set last releases SDA on the ninth clock, which ends the read
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(last, s);
  endtask
endmodule

/* tb/sitp_target_tb_top.sv */
`timescale 1ns/100ps
module sitp_target_tb_top import sitp_pkg::*;;
  logic i_sys_clk, i_rst, i_link_clk, i_port_sel, i_addr_sel_strap;
  logic o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, o_reg_wr, o_reg_rd;
  logic [7:0] i_reg_rdata, o_reg_addr, o_reg_wdata;
  logic ctl_scl_low, ctl_sda_low, scl_w, sda_w;
  logic [7:0] mem [256];
  logic [7:0] shadow [256];
  logic [16:0] exp_q [$];
  int errors, checks_done;

  // Open-drain wires with pull-ups
  assign scl_w = (o_scl_oe_n ? 1'b1 : o_scl_out) & !ctl_scl_low;
  assign sda_w = (o_sda_oe_n ? 1'b1 : o_sda_out) & !ctl_sda_low;

  sitp_target sitp_target_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
    .i_port_sel(i_port_sel), .i_addr_sel_strap(i_addr_sel_strap),
    .i_scl(scl_w), .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n),
    .i_sda(sda_w), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd), .o_reg_addr(o_reg_addr),
    .o_reg_wdata(o_reg_wdata), .i_reg_rdata(i_reg_rdata)
  );

  sitp_ctl_model sitp_ctl_model_i (
    .i_scl(scl_w), .i_sda(sda_w), .o_scl_low(ctl_scl_low), .o_sda_low(ctl_sda_low)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = !i_sys_clk;
  end

  // Link clock with an odd offset so its edges never line up with the system clock
  initial begin
    i_link_clk = 1'b0;
    #17.3;
    forever #62.5 i_link_clk = !i_link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register space: answers reads one cycle late, noise on the data otherwise
  always @(posedge i_sys_clk) begin
    if (o_reg_rd === 1'b1) begin
      i_reg_rdata <= mem[o_reg_addr];
    end else begin
      i_reg_rdata <= 8'($urandom);
    end
    if (o_reg_wr === 1'b1) begin
      mem[o_reg_addr] <= o_reg_wdata;
    end
    if (o_reg_wr === 1'b1 || o_reg_rd === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("strobe", 17'h0, {o_reg_wr, o_reg_addr, o_reg_wdata});
      end else begin
        check("strobe", exp_q.pop_front(), {o_reg_wr, o_reg_addr,
          o_reg_wr ? o_reg_wdata : 8'h00});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_regs(input logic [6:0] a, input logic [7:0] ptr, input int n);
    logic ack;
    logic [7:0] d;
    sitp_ctl_model_i.start();
    sitp_ctl_model_i.send_byte({a, 1'b0}, ack);
    check("write address ack", 17'h1, 17'(ack));
    sitp_ctl_model_i.send_byte(ptr, ack);
    check("pointer ack", 17'h1, 17'(ack));
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      shadow[8'(ptr + k)] = d;
      exp_q.push_back({1'b1, 8'(ptr + k), d});
      sitp_ctl_model_i.send_byte(d, ack);
      check("data ack", 17'h1, 17'(ack));
    end
    sitp_ctl_model_i.stop();
  endtask

  // Restart selects a repeated start, otherwise a stop then a start
  task automatic rd_regs(input logic [6:0] a, input logic [7:0] ptr, input int n,
                         input logic restart);
    logic ack;
    logic [7:0] d;
    sitp_ctl_model_i.start();
    sitp_ctl_model_i.send_byte({a, 1'b0}, ack);
    check("write address ack", 17'h1, 17'(ack));
    sitp_ctl_model_i.send_byte(ptr, ack);
    check("pointer ack", 17'h1, 17'(ack));
    if (!restart) begin
      sitp_ctl_model_i.stop();
    end
    sitp_ctl_model_i.start();
    for (int k = 0; k < n; k++) begin
      exp_q.push_back({1'b0, 8'(ptr + k), 8'h00});
    end
    sitp_ctl_model_i.send_byte({a, 1'b1}, ack);
    check("read address ack", 17'h1, 17'(ack));
    for (int k = 0; k < n; k++) begin
      sitp_ctl_model_i.recv_byte(k == n - 1, d);
      check("read data", 17'(shadow[8'(ptr + k)]), 17'(d));
    end
    sitp_ctl_model_i.stop();
  endtask

  task automatic no_answer(input logic [6:0] a);
    logic ack;
    sitp_ctl_model_i.start();
    sitp_ctl_model_i.send_byte({a, 1'b0}, ack);
    check("refused address ack", 17'h0, 17'(ack));
    sitp_ctl_model_i.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run needs about 470 us of bus time
  initial begin
    #700000;
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    i_rst = 1'b1;
    i_port_sel = 1'b1;
    i_addr_sel_strap = 1'b1;
    void'($urandom(32'h237c));
    for (int k = 0; k < 256; k++) begin
      mem[k] = 8'($urandom);
      shadow[k] = mem[k];
    end
    // Held over link clock cycles: the link reset needs two of its edges
    repeat (4) @(posedge i_link_clk);
    @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    #2000;
    wr_regs(ADDR_STRAP_HI, 8'hfe, 3);
    rd_regs(ADDR_STRAP_HI, 8'hfe, 3, 1'b1);
    no_answer(ADDR_STRAP_LO);
    @(posedge i_sys_clk);
    #1 i_addr_sel_strap = 1'b0;
    #2000;
    rd_regs(ADDR_STRAP_LO, 8'($urandom), 1, 1'b0);
    no_answer(ADDR_STRAP_HI);
    @(posedge i_sys_clk);
    #1 i_port_sel = 1'b0;
    #2000;
    no_answer(ADDR_STRAP_LO);
    #2000;
    check("pending strobes", 17'h0, 17'(exp_q.size()));
    end_of_test();
  end
endmodule
